// ===== logic/hdlc_rx_pkg.sv
// Operation
// RL1 - Clearing enable stops reception, flushes the FIFO, clears interrupts, keeps selects.
// RL2 - Setting enable starts the hunt for an opening flag at once.
// RL3 - Terminate abandons the frame, flushes, clears interrupts and restarts the hunt.
// RL4 - Terminate clears itself one clock after its write completes; reads return zero (the code reads back term_q during that clock).
// RL5 - After terminate or re-enable the first flag found raises an interrupt.
// RL6 - Two-bit select: off, any byte, two bytes held, three bytes held.
// RL7 - Interrupt bit mirrors the output; when off, output is low, bit shows latch.
// RL8 - Also interrupt on end of message, overrun, abort, and first flag after ones.
// RL9 - A data read emptying the FIFO clears non-overrun interrupts; pointer moves after read.
// RL10 - Overrun interrupt clears only by status read, disable or terminate.
// RL11 - Software changes interrupt selects only while the receiver is disabled.
// RL12 - Valid count is valid bits minus one, filled from the top bit downward.
// RL13 - CRC error marks a failed frame check; meaningful only with end and flag.
// RL14 - End of message shows with last, abort or dummy byte, and on overrun.
// RL15 - Flag-seen sets on a flag, clears on abort or disable; eight ones abort (the code aborts on the seventh one).
// RL16 - Overrun holds receiver and FIFO in reset until a status read.
// RL17 - Four FIFO entries; empty rises on last read, falls on a new load.
// RL18 - A data read of an empty FIFO keeps the pointer; next status reads zero.
// RL19 - In a full byte bit 0 holds the first serial bit, bit 7 the last.
// RL20 - Software reads data within 31 or 15 link bit periods of the interrupt.
// RL21 - An abort writes the partially shifted bits into the FIFO and interrupts.
// RL22 - One bit per link strobe; zeros after five ones are removed.
package hdlc_rx_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] IDX_CONFIG = 8'h38;
  localparam logic [7:0] IDX_IRQ_CTL = 8'h39;
  localparam logic [7:0] IDX_STATUS = 8'h3A;
  localparam logic [7:0] IDX_DATA = 8'h3B;
  localparam logic [7:0] ADDR_CONFIG = 8'(IDX_CONFIG * 8'h04);
  localparam logic [7:0] ADDR_IRQ_CTL = 8'(IDX_IRQ_CTL * 8'h04);
  localparam logic [7:0] ADDR_STATUS = 8'(IDX_STATUS * 8'h04);
  localparam logic [7:0] ADDR_DATA = 8'(IDX_DATA * 8'h04);

  localparam int CFG_EN_BIT = 0;
  localparam int CFG_TERM_BIT = 1;
  localparam int IRQ_SEL_LSB = 1;
  localparam int IRQ_SEL_MSB = 2;
  localparam logic [1:0] IRQ_SEL_OFF = 2'h0;
  localparam logic [1:0] IRQ_SEL_TWO = 2'h2;
  localparam logic [1:0] IRQ_SEL_THREE = 2'h3;

  // ==========================================================================
  // Line coding
  localparam logic [2:0] STUFF_ONES = 3'h5;
  localparam logic [2:0] FLAG_ONES = 3'h6;
  localparam logic [2:0] MAX_ONES = 3'h7;
  localparam logic [2:0] DELAY_LEN = 3'h7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [2:0] NVB_FULL = 3'h7;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_GOOD = 16'hF0B8;
  localparam int FIFO_DEPTH_DEF = 4;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {RX_OFF, RX_ONES, RX_SYNC} rx_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic [2:0] valid_bit_count;
    logic end_of_message;
    logic flag_seen;
    logic crc_err;
  } fifo_entry_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } ahb_req_t;

endpackage

// ===== logic/hdlc_datalink_receiver.sv
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module hdlc_datalink_receiver
  import hdlc_rx_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic i_link_data,
  input wire logic i_link_bit_en,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic o_rx_link_irq_out,
  output logic o_end_of_message_out
);

  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(FIFO_DEPTH);

  // ==========================================================================
  // Helpers
  function automatic logic [CW-1:0] fill_threshold(input logic [1:0] sel);
    case (sel)
      IRQ_SEL_TWO: fill_threshold = CW'(2);
      IRQ_SEL_THREE: fill_threshold = CW'(3);
      default: fill_threshold = CW'(1);
    endcase
  endfunction

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(FIFO_DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = (c[0] ^ b) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
  endfunction

  // ==========================================================================
  // State
  ahb_req_t req_q, req_d;
  logic [7:0] hrdata_q, hrdata_d;
  logic en_q, en_d, term_q, term_d;
  logic [1:0] sel_q, sel_d;
  rx_state_t state_q, state_d;
  logic [2:0] ones_q, ones_d, dcnt_q, dcnt_d;
  logic [6:0] dl_q, dl_d;
  logic [7:0] acc_q, acc_d, hold_q, hold_d;
  logic [3:0] acnt_q, acnt_d;
  logic hold_v_q, hold_v_d, tail_v_q, tail_v_d;
  fifo_entry_t tail_q, tail_d, last_q, last_d;
  logic [15:0] crc_q, crc_d;
  fifo_entry_t fifo_q [FIFO_DEPTH];
  fifo_entry_t fifo_d [FIFO_DEPTH];
  logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic ovr_q, ovr_d, irq_q, irq_d, udr_q, udr_d;

  logic irq_int;
  logic empty;
  fifo_entry_t head;

  // Overrun always sets the internal interrupt, whatever the fill level and select.
  assign irq_int = irq_q | ovr_q;
  assign empty = (cnt_q == '0);
  assign head = fifo_q[rp_q];

  // Every access completes with no wait state; reads are decoded in the address
  // phase so that the data register pops exactly once per transfer.
  assign o_hrdata = {24'h000000, hrdata_q};
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_rx_link_irq_out = (sel_q != IRQ_SEL_OFF) & irq_int; // RL7
  assign o_end_of_message_out = last_q.end_of_message | ovr_q; // RL14

  // ==========================================================================
  // Next state
  always_comb begin
    logic acc_ok;
    logic rd;
    logic wr;
    logic push;
    logic pop;
    logic b;
    fifo_entry_t pent;
    fifo_entry_t part;
    logic [7:0] acc_n;
    logic [CW-1:0] cnt_t;
    acc_ok = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    b = 1'b0;
    pent = '0;
    part = '0;
    acc_n = '0;
    cnt_t = '0;
    req_d = req_q;
    hrdata_d = '0;
    en_d = en_q;
    term_d = 1'b0; // RL4
    sel_d = sel_q;
    state_d = state_q;
    ones_d = ones_q;
    dcnt_d = dcnt_q;
    dl_d = dl_q;
    acc_d = acc_q;
    acnt_d = acnt_q;
    hold_d = hold_q;
    hold_v_d = hold_v_q;
    tail_v_d = tail_v_q;
    tail_d = tail_q;
    last_d = last_q;
    crc_d = crc_q;
    fifo_d = fifo_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    ovr_d = ovr_q;
    irq_d = irq_q;
    udr_d = udr_q;

    // Address phase is decoded here; reads answer in the data phase.
    acc_ok = i_hsel & i_hready & i_htrans[1];
    rd = acc_ok & ~i_hwrite;
    wr = req_q.valid & req_q.write;
    req_d = '{valid: acc_ok, write: i_hwrite, addr: i_haddr[7:0]};

    if (wr && req_q.addr == ADDR_CONFIG) begin
      en_d = i_hwdata[CFG_EN_BIT];
      term_d = i_hwdata[CFG_TERM_BIT];
    end
    if (wr && req_q.addr == ADDR_IRQ_CTL) begin
      sel_d = i_hwdata[IRQ_SEL_MSB:IRQ_SEL_LSB]; // RL6
    end

    if (rd) begin
      case (i_haddr[7:0])
        ADDR_CONFIG: hrdata_d = {6'h00, term_q, en_q};
        ADDR_IRQ_CTL: begin
          hrdata_d = {5'h00, sel_q, (sel_q == IRQ_SEL_OFF) ? irq_int : o_rx_link_irq_out}; // RL7
        end
        ADDR_STATUS: begin
          if (!udr_q) begin
            hrdata_d = {empty, ovr_q, last_q.flag_seen, last_q.end_of_message | ovr_q, last_q.crc_err,
                        last_q.valid_bit_count}; // RL12 RL13 RL14 RL17
          end
          ovr_d = 1'b0; // RL10
          udr_d = 1'b0; // RL18
        end
        ADDR_DATA: begin
          if (empty) begin
            // Underrun is remembered only until the next status read.
            udr_d = 1'b1; // RL18
          end else begin
            hrdata_d = head.data; // RL19
            pop = 1'b1;
          end
        end
        default: hrdata_d = '0;
      endcase
    end

    if (pop) begin
      last_d = head; // RL14
      rp_d = ptr_inc(rp_q); // RL9
    end
    // A pop and a push in one cycle leave the count where it was.
    cnt_t = pop ? CW'(cnt_q - 1'b1) : cnt_q;
    if (pop && cnt_t == '0) begin
      irq_d = 1'b0; // RL9
    end

    // Partial tail of a frame that ended while an older byte was still held.
    if (tail_v_q) begin
      push = 1'b1;
      pent = tail_q;
      tail_v_d = 1'b0;
    end else if (state_q == RX_OFF) begin
      if (en_q) begin
        state_d = RX_ONES; // RL2
      end
    end else if (i_link_bit_en) begin
      b = i_link_data; // RL22
      ones_d = b ? ((ones_q == MAX_ONES) ? MAX_ONES : 3'(ones_q + 1'b1)) : '0;
      part = '{data: acc_q, valid_bit_count: (acnt_q == '0) ? 3'h0 : 3'(acnt_q - 1'b1),
               end_of_message: 1'b1, flag_seen: 1'b1, crc_err: (crc_q != CRC_GOOD)};
      if (b && ones_q == FLAG_ONES) begin
        // Seventh one: abort. While already in all-ones this is silent.
        if (state_q == RX_SYNC) begin
          part.flag_seen = 1'b0; // RL15
          part.crc_err = 1'b0;
          push = 1'b1; // RL21
          if (hold_v_q) begin
            pent = '{data: hold_q, valid_bit_count: NVB_FULL, end_of_message: 1'b0, flag_seen: 1'b1, crc_err: 1'b0};
            tail_d = part;
            tail_v_d = 1'b1;
          end else begin
            pent = part;
          end
        end
        state_d = RX_ONES;
        dcnt_d = '0;
        acnt_d = '0;
        hold_v_d = 1'b0;
        crc_d = CRC_INIT;
      end else if (!b && ones_q == FLAG_ONES) begin
        if (state_q == RX_ONES) begin
          push = 1'b1; // RL5 RL8
          pent = '{data: 8'h00, valid_bit_count: 3'h0, end_of_message: 1'b1, flag_seen: 1'b1, crc_err: 1'b0};
        end else if (hold_v_q || acnt_q != '0) begin
          push = 1'b1;
          if (acnt_q == '0) begin
            pent = '{data: hold_q, valid_bit_count: NVB_FULL, end_of_message: 1'b1, flag_seen: 1'b1,
                     crc_err: (crc_q != CRC_GOOD)}; // RL13
          end else if (hold_v_q) begin
            pent = '{data: hold_q, valid_bit_count: NVB_FULL, end_of_message: 1'b0, flag_seen: 1'b1, crc_err: 1'b0};
            tail_d = part;
            tail_v_d = 1'b1;
          end else begin
            pent = part;
          end
        end
        state_d = RX_SYNC; // RL15
        dcnt_d = '0;
        acnt_d = '0;
        hold_v_d = 1'b0;
        crc_d = CRC_INIT;
      end else if (!b && ones_q == STUFF_ONES) begin
        dcnt_d = dcnt_q; // RL22
      end else if (state_q == RX_SYNC) begin
        // Seven bits lag behind the line so a closing flag never reaches the byte.
        dl_d = {b, dl_q[6:1]};
        if (dcnt_q == DELAY_LEN) begin
          acc_n = {dl_q[0], acc_q[7:1]}; // RL12 RL19
          acc_d = acc_n;
          crc_d = crc_step(crc_q, dl_q[0]);
          if (4'(acnt_q + 1'b1) == BYTE_BITS) begin
            acnt_d = '0;
            if (hold_v_q) begin
              push = 1'b1;
              pent = '{data: hold_q, valid_bit_count: NVB_FULL, end_of_message: 1'b0, flag_seen: 1'b1, crc_err: 1'b0};
            end
            hold_d = acc_n;
            hold_v_d = 1'b1;
          end else begin
            acnt_d = 4'(acnt_q + 1'b1);
          end
        end else begin
          dcnt_d = 3'(dcnt_q + 1'b1);
        end
      end
    end

    // Set wins: a push in the cycle of an emptying read keeps the interrupt if it ends a message or meets the fill threshold.
    if (push) begin
      if (cnt_t == CNT_FULL) begin
        ovr_d = 1'b1; // RL16
      end else begin
        fifo_d[wp_q] = pent;
        wp_d = ptr_inc(wp_q);
        cnt_t = CW'(cnt_t + 1'b1); // RL17
        if (pent.end_of_message || cnt_t >= fill_threshold(sel_q)) begin
          irq_d = 1'b1; // RL6 RL8
        end
      end
    end
    cnt_d = cnt_t;

    // Overrun keeps the receiver and FIFO in reset until the status read.
    if (ovr_q || ovr_d) begin
      state_d = en_q ? RX_ONES : RX_OFF; // RL16
      wp_d = '0;
      rp_d = '0;
      cnt_d = '0;
      last_d = '0;
      tail_v_d = 1'b0;
      hold_v_d = 1'b0;
      acnt_d = '0;
      dcnt_d = '0;
      ones_d = '0;
      crc_d = CRC_INIT;
      // The fill latch is cleared too, so that a flushed FIFO cannot leave a
      // level interrupt that no data read could ever clear.
      irq_d = 1'b0; // RL16
    end

    // Disable or terminate restart everything but the select field and the underrun flag.
    if (!en_q || term_q) begin
      // Terminate lasts one cycle, after which the hunt restarts in all-ones.
      state_d = en_q ? RX_ONES : RX_OFF; // RL1 RL3
      wp_d = '0;
      rp_d = '0;
      cnt_d = '0;
      last_d = '0; // RL15
      tail_v_d = 1'b0;
      hold_v_d = 1'b0;
      acnt_d = '0;
      dcnt_d = '0;
      ones_d = '0;
      crc_d = CRC_INIT;
      irq_d = 1'b0; // RL1 RL3
      ovr_d = 1'b0; // RL10
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_q <= '0;
      hrdata_q <= '0;
      en_q <= 1'b0;
      term_q <= 1'b0;
      sel_q <= IRQ_SEL_OFF;
      state_q <= RX_OFF;
      ones_q <= '0;
      dcnt_q <= '0;
      dl_q <= '0;
      acc_q <= '0;
      acnt_q <= '0;
      hold_q <= '0;
      hold_v_q <= 1'b0;
      tail_v_q <= 1'b0;
      tail_q <= '0;
      last_q <= '0;
      crc_q <= CRC_INIT;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        fifo_q[i] <= '0;
      end
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      ovr_q <= 1'b0;
      irq_q <= 1'b0;
      udr_q <= 1'b0;
    end else begin
      req_q <= req_d;
      hrdata_q <= hrdata_d;
      en_q <= en_d;
      term_q <= term_d;
      sel_q <= sel_d;
      state_q <= state_d;
      ones_q <= ones_d;
      dcnt_q <= dcnt_d;
      dl_q <= dl_d;
      acc_q <= acc_d;
      acnt_q <= acnt_d;
      hold_q <= hold_d;
      hold_v_q <= hold_v_d;
      tail_v_q <= tail_v_d;
      tail_q <= tail_d;
      last_q <= last_d;
      crc_q <= crc_d;
      fifo_q <= fifo_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      ovr_q <= ovr_d;
      irq_q <= irq_d;
      udr_q <= udr_d;
    end
  end

endmodule // hdlc_datalink_receiver

// ===== test/hdlc_rx_asserts.sv
`timescale 1ns/1ps
// ==========================================================================
// Port checker
module hdlc_rx_asserts
  import hdlc_rx_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic o_rx_link_irq_out
);
  ahb_req_t req_d, req_q;
  logic [1:0] sel_d, sel_q;
  logic cfg_wr, rd_ph;
  always_comb begin
    req_d = '{valid: i_hsel & i_hready & i_htrans[1], write: i_hwrite, addr: i_haddr[7:0]};
    sel_d = sel_q;
    if (req_q.valid && req_q.write && req_q.addr == ADDR_IRQ_CTL) begin
      sel_d = i_hwdata[IRQ_SEL_MSB:IRQ_SEL_LSB];
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_q <= '0;
      sel_q <= IRQ_SEL_OFF;
    end else begin
      req_q <= req_d;
      sel_q <= sel_d;
    end
  end
  assign cfg_wr = req_q.valid & req_q.write & (req_q.addr == ADDR_CONFIG);
  assign rd_ph = req_q.valid & ~req_q.write;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  property p_okay; o_hresp == 1'b0 && o_hreadyout == 1'b1; endproperty
  a_okay: assert property (p_okay) else $error("bus answer not zero-wait OKAY");
  property p_idle; !rd_ph |-> o_hrdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside data phase");
  property p_upper; rd_ph |-> o_hrdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits not zero");
  property p_unmapped; rd_ph && req_q.addr < ADDR_CONFIG |-> o_hrdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_sel_off; sel_q == IRQ_SEL_OFF |-> !o_rx_link_irq_out; endproperty
  a_sel_off: assert property (p_sel_off) else $error("interrupt while disabled");
  property p_mirror;
    rd_ph && req_q.addr == ADDR_IRQ_CTL && $past(sel_q) != IRQ_SEL_OFF
      |-> o_hrdata[0] == $past(o_rx_link_irq_out);
  endproperty
  a_mirror: assert property (p_mirror) else $error("interrupt bit not mirrored");
  property p_disable;
    cfg_wr && !i_hwdata[CFG_EN_BIT] |=> ##1 !o_rx_link_irq_out;
  endproperty
  a_disable: assert property (p_disable) else $error("disable kept interrupt");
  property p_term; cfg_wr && i_hwdata[CFG_TERM_BIT] |=> ##1 !o_rx_link_irq_out; endproperty
  a_term: assert property (p_term) else $error("terminate kept interrupt");
  property p_ovr;
    rd_ph && req_q.addr == ADDR_STATUS && o_hrdata[6] |-> o_hrdata[5:0] == 6'h10;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun status wrong");
  c_irq: cover property ($rose(o_rx_link_irq_out));
  c_ovr: cover property (rd_ph && req_q.addr == ADDR_STATUS && o_hrdata[6]);
  c_term: cover property (cfg_wr && i_hwdata[CFG_TERM_BIT]);
endmodule // hdlc_rx_asserts

bind hdlc_datalink_receiver hdlc_rx_asserts i_hdlc_rx_asserts (
  .i_ref_clk(i_ref_clk),
  .i_rst_n(i_rst_n),
  .i_hsel(i_hsel),
  .i_haddr(i_haddr),
  .i_htrans(i_htrans),
  .i_hwrite(i_hwrite),
  .i_hwdata(i_hwdata),
  .i_hready(i_hready),
  .o_hrdata(o_hrdata),
  .o_hreadyout(o_hreadyout),
  .o_hresp(o_hresp),
  .o_rx_link_irq_out(o_rx_link_irq_out)
);

// ===== test/link_framer_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Serial link source
module link_framer_model (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_go,
  input wire logic [7:0] i_byte,
  output logic o_busy,
  output logic o_link_data,
  output logic o_link_bit_en
);
  logic [7:0] sh_d, sh_q;
  logic [4:0] cnt_d, cnt_q;
  logic busy_d, data_d, en_d;
  always_comb begin
    sh_d = sh_q;
    cnt_d = cnt_q;
    busy_d = o_busy;
    en_d = 1'b0;
    // The line toggles between strobes so a stale bit is never mistaken for data.
    data_d = ~o_link_data;
    if (!o_busy) begin
      if (i_go) begin
        busy_d = 1'b1;
        sh_d = i_byte;
        cnt_d = 5'h00;
      end
    end else begin
      cnt_d = cnt_q + 5'h01;
      busy_d = (cnt_q != 5'h1F);
      if (cnt_q[1:0] == 2'h1) begin
        en_d = 1'b1;
        data_d = sh_q[cnt_q[4:2]];
      end
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sh_q <= 8'h00;
      cnt_q <= 5'h00;
      o_busy <= 1'b0;
      o_link_data <= 1'b0;
      o_link_bit_en <= 1'b0;
    end else begin
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      o_busy <= busy_d;
      o_link_data <= data_d;
      o_link_bit_en <= en_d;
    end
  end
endmodule // link_framer_model

// ===== test/hdlc_datalink_receiver_test.sv
`timescale 1ns/1ps
module hdlc_datalink_receiver_test;
  import hdlc_rx_pkg::*;
  logic ref_clk, rst_n, hsel, hwrite, hready, hresp, ldat, len, irq, end_of_message, pm_go, pm_busy;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0] pm_byte;
  int fails = 0;
  int total_checks = 0;
  hdlc_datalink_receiver i_hdlc_datalink_receiver (.i_ref_clk(ref_clk), .i_rst_n(rst_n),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hready), .i_link_data(ldat), .i_link_bit_en(len),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .o_rx_link_irq_out(irq),
    .o_end_of_message_out(end_of_message));
  link_framer_model i_link_framer_model (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_go(pm_go),
    .i_byte(pm_byte), .o_busy(pm_busy), .o_link_data(ldat), .o_link_bit_en(len));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ==========================================================================
  // Shared tasks
  task automatic print_verdict;
    if (fails == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic edge_rdy;
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) begin
        fails++;
        print_verdict();
      end
      @(posedge ref_clk);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    edge_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    edge_rdy();
    rd = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check(rd[7:0] & mask, exp);
  endtask
  task automatic send(input logic [7:0] b, input int cnt);
    int n;
    repeat (cnt) begin
      pm_byte <= b;
      pm_go <= 1'b1;
      @(posedge ref_clk);
      pm_go <= 1'b0;
      n = 0;
      do begin
        @(posedge ref_clk);
        n++;
      end while (pm_busy !== 1'b0 && n < 200);
      if (n >= 200) begin
        fails++;
        print_verdict();
      end
    end
    repeat (3) @(posedge ref_clk);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic start(input logic [1:0] prev, input logic [1:0] sel);
    bus(1'b1, ADDR_CONFIG, 8'h00);
    // The cleared latch shows one cycle after the write.
    @(posedge ref_clk);
    rdc(ADDR_IRQ_CTL, 8'h07, {5'h0, prev, 1'b0});
    bus(1'b1, ADDR_IRQ_CTL, {5'h0, sel, 1'b0});
    bus(1'b1, ADDR_CONFIG, 8'h01);
    send(8'hFF, 1);
    send(8'h7E, 1);
    check({7'h0, irq}, {7'h0, sel != IRQ_SEL_OFF});
    rdc(ADDR_IRQ_CTL, 8'h01, 8'h01);
    rdc(ADDR_DATA, 8'hFF, 8'h00);
    rdc(ADDR_STATUS, 8'hF0, 8'hB0);
    check({7'h0, irq}, 8'h00);
  endtask
  task automatic fill(input logic [1:0] sel);
    start(sel - 2'h1, sel);
    // The bit delay and the held last byte keep two sent bytes out of the FIFO.
    send(8'h3C, int'(sel) + 1);
    check({7'h0, irq}, 8'h00);
    send(8'h3C, 1);
    check({7'h0, irq}, 8'h01);
    rdc(ADDR_DATA, 8'hFF, 8'h3C);
  endtask
  task automatic frame_end;
    send(8'h3C, 2);
    send(8'h7E, 1);
    rdc(ADDR_DATA, 8'hFF, 8'h3C);
    rdc(ADDR_DATA, 8'hFF, 8'h3C);
    rdc(ADDR_STATUS, 8'hFF, 8'hBF);
    check({7'h0, end_of_message}, 8'h01);
  endtask
  task automatic overrun;
    send(8'h3C, 3);
    check({7'h0, end_of_message}, 8'h01);
    check({7'h0, irq}, 8'h01);
    rdc(ADDR_DATA, 8'hFF, 8'h00);
    check({7'h0, irq}, 8'h01);
    rdc(ADDR_STATUS, 8'hFF, 8'h00);
    rdc(ADDR_STATUS, 8'hC0, 8'h80);
    check({7'h0, irq}, 8'h00);
    send(8'h7E, 1);
    send(8'h3C, 6);
    rdc(ADDR_STATUS, 8'hFF, 8'hD0);
    check({7'h0, irq}, 8'h00);
    check({7'h0, end_of_message}, 8'h00);
  endtask
  task automatic term_abort;
    start(2'h3, 2'h1);
    send(8'h3C, 2);
    bus(1'b1, ADDR_CONFIG, 8'h03);
    repeat (2) @(posedge ref_clk);
    rdc(ADDR_CONFIG, 8'h03, 8'h01);
    check({7'h0, irq}, 8'h00);
    rdc(ADDR_STATUS, 8'h80, 8'h80);
    send(8'h7E, 1);
    check({7'h0, irq}, 8'h01);
    rdc(ADDR_DATA, 8'hFF, 8'h00);
    send(8'h3C, 1);
    send(8'hFE, 1);
    check({7'h0, irq}, 8'h01);
    rdc(ADDR_DATA, 8'hFF, 8'h3C);
    bus(1'b0, ADDR_DATA, 8'h00);
    rdc(ADDR_STATUS, 8'hF0, 8'h90);
  endtask
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    pm_go = 1'b0;
    pm_byte = 8'h00;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdc(ADDR_CONFIG, 8'hFF, 8'h00);
    rdc(ADDR_IRQ_CTL, 8'hFF, 8'h00);
    bus(1'b1, 8'h00, 8'hFF);
    rdc(8'h00, 8'hFF, 8'h00);
    rdc(ADDR_CONFIG, 8'hFF, 8'h00);
    start(2'h0, 2'h0);
    frame_end();
    for (int s = 1; s < 4; s++) begin
      fill(2'(s));
    end
    overrun();
    term_abort();
    print_verdict();
  end
endmodule // hdlc_datalink_receiver_test
